/* verilog/srce_executor.sv */
// Sequence register command executor: registers, loop counters and schedule parameter moves.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Code 61 adds register[high] and register[low] into register 0, updates condition code.
// - Code 62 copies encoder pulse accumulator into register[low].
// - Codes 63..72 load registers 1..10 with the argument value.
// - Code 73 increments loop counter[arg]; indices 0 to 9 are valid.
// - Code 74 starts the weld using loop counter[low] as schedule number.
// - Code 75 copies schedule parameter[high] into register[low].
// - Code 76 writes register[low] into schedule parameter[high].
module srce_executor #(
  parameter int REG_COUNT = srce_pkg::SRCE_REG_COUNT,
  parameter int LOOP_COUNT = srce_pkg::SRCE_LOOP_COUNT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Command slot
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] arg_high_i,
  input wire logic [7:0] arg_low_i,
  output logic cmd_done_o,
  // Encoder pulse accumulator
  input wire logic [15:0] pulse_accum_i,
  // Weld sequence control
  output logic weld_start_o,
  output logic [15:0] weld_schedule_o,
  output logic param_rd_o,
  output logic param_wr_o,
  output logic [7:0] param_index_o,
  output logic [15:0] param_wdata_o,
  input wire logic [15:0] param_rdata_i,
  input wire logic param_rvalid_i,
  // State
  output logic [1:0] cond_code_o
);
  import srce_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] regs_q [REG_COUNT];
  logic [15:0] loops_q [LOOP_COUNT];
  srce_state_type state_q;
  logic [3:0] pend_reg_q;
  logic pend_ok_q;
  logic [15:0] sum;
  logic [1:0] sum_cc;
  logic [15:0] op_high;
  logic [15:0] op_low;
  logic [15:0] loop_sel;
  logic reg_high_ok;
  logic reg_low_ok;
  logic loop_low_ok;
  logic accept;
  logic [7:0] load_idx;

  assign reg_high_ok = arg_high_i < 8'(REG_COUNT);
  assign reg_low_ok = arg_low_i < 8'(REG_COUNT);
  assign loop_low_ok = arg_low_i < 8'(LOOP_COUNT);
  assign op_high = reg_high_ok ? regs_q[arg_high_i[3:0]] : 16'h0000;
  assign op_low = reg_low_ok ? regs_q[arg_low_i[3:0]] : 16'h0000;
  assign loop_sel = loop_low_ok ? loops_q[arg_low_i[3:0]] : 16'h0000;
  assign accept = cmd_valid_i && (state_q == SRCE_IDLE);
  assign load_idx = cmd_code_i - SRCE_CMD_LOAD_FIRST + 8'h01;

  srce_adder u_adder (
    .a_i(op_high),
    .b_i(op_low),
    .sum_o(sum),
    .cc_o(sum_cc)
  );

  // ----------------------------------------
  // Sequencer for parameter reads
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= SRCE_IDLE;
      pend_reg_q <= 4'h0;
      pend_ok_q <= 1'b0;
    end else begin
      case (state_q)
        SRCE_IDLE: begin
          if (accept && cmd_code_i == SRCE_CMD_READ_PARAM) begin
            state_q <= SRCE_PARAM_WAIT;
            pend_reg_q <= arg_low_i[3:0];
            // The full byte is judged here so that a large index cannot alias onto a low register.
            pend_ok_q <= reg_low_ok;
          end
        end
        SRCE_PARAM_WAIT: begin
          if (param_rvalid_i) begin
            state_q <= SRCE_IDLE;
          end
        end
        default: begin
          state_q <= SRCE_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Program registers
  // ----------------------------------------
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
        regs_q[g] <= SRCE_REG_RESET;
      end else if (state_q == SRCE_PARAM_WAIT && param_rvalid_i) begin
        if (pend_reg_q == 4'(g) && pend_ok_q) begin
          regs_q[g] <= param_rdata_i;
        end
      end else if (accept) begin
        if (cmd_code_i == SRCE_CMD_ADD && g == 0) begin
          regs_q[g] <= sum;
        end else if (cmd_code_i == SRCE_CMD_SAVE_PULSE && arg_low_i == 8'(g)) begin
          regs_q[g] <= pulse_accum_i;
        end else if (cmd_code_i >= SRCE_CMD_LOAD_FIRST && cmd_code_i <= SRCE_CMD_LOAD_LAST
                     && load_idx == 8'(g)) begin
          regs_q[g] <= {arg_high_i, arg_low_i};
        end
      end
    end
  end

  // ----------------------------------------
  // Loop counters
  // ----------------------------------------
  for (genvar g = 0; g < LOOP_COUNT; g++) begin : g_loop
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
        loops_q[g] <= SRCE_LOOP_RESET;
      end else if (accept && cmd_code_i == SRCE_CMD_INC_LOOP && arg_low_i == 8'(g)) begin
        loops_q[g] <= loops_q[g] + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Condition code
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cond_code_o <= SRCE_CC_RESET;
    end else if (accept && cmd_code_i == SRCE_CMD_ADD) begin
      cond_code_o <= sum_cc;
    end
  end

  // ----------------------------------------
  // Weld start and parameter port
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      weld_start_o <= 1'b0;
      weld_schedule_o <= 16'h0000;
      param_rd_o <= 1'b0;
      param_wr_o <= 1'b0;
      param_index_o <= 8'h00;
      param_wdata_o <= 16'h0000;
    end else begin
      weld_start_o <= 1'b0;
      param_rd_o <= 1'b0;
      param_wr_o <= 1'b0;
      if (accept && cmd_code_i == SRCE_CMD_START_WELD && loop_low_ok) begin
        weld_start_o <= 1'b1;
        weld_schedule_o <= loop_sel;
      end
      if (accept && cmd_code_i == SRCE_CMD_READ_PARAM) begin
        param_rd_o <= 1'b1;
        param_index_o <= arg_high_i;
      end
      if (accept && cmd_code_i == SRCE_CMD_WRITE_PARAM) begin
        param_wr_o <= 1'b1;
        param_index_o <= arg_high_i;
        param_wdata_o <= op_low;
      end
    end
  end

  // ----------------------------------------
  // Completion
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_done_o <= 1'b0;
    end else begin
      cmd_done_o <= (accept && cmd_code_i != SRCE_CMD_READ_PARAM)
                    || (state_q == SRCE_PARAM_WAIT && param_rvalid_i);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_add_result: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    accept && cmd_code_i == SRCE_CMD_ADD |=> regs_q[0] == $past(sum) && cond_code_o == $past(sum_cc))
    else $error("add result wrong");
  a_pulse_save: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    accept && cmd_code_i == SRCE_CMD_SAVE_PULSE && arg_low_i == 8'h04 |=> regs_q[4] == $past(pulse_accum_i))
    else $error("pulse save wrong");
  a_load_first: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    accept && cmd_code_i == SRCE_CMD_LOAD_FIRST |=> regs_q[1] == {$past(arg_high_i), $past(arg_low_i)})
    else $error("load register 1 wrong");
  a_load_last: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    accept && cmd_code_i == SRCE_CMD_LOAD_LAST |=> regs_q[10] == {$past(arg_high_i), $past(arg_low_i)})
    else $error("load register 10 wrong");
  a_loop_inc: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    accept && cmd_code_i == SRCE_CMD_INC_LOOP && arg_low_i == 8'h02 |=> loops_q[2] == $past(loops_q[2]) + 16'h0001)
    else $error("loop increment wrong");
  a_weld_start: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    accept && cmd_code_i == SRCE_CMD_START_WELD && loop_low_ok |=> weld_start_o && weld_schedule_o == $past(loop_sel)
    ##1 (!weld_start_o || $past(accept && cmd_code_i == SRCE_CMD_START_WELD)))
    else $error("weld start wrong");
  a_param_read: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state_q == SRCE_PARAM_WAIT && param_rvalid_i && pend_ok_q && pend_reg_q == 4'h5
    |=> regs_q[5] == $past(param_rdata_i) && cmd_done_o)
    else $error("parameter read wrong");
  a_param_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    accept && cmd_code_i == SRCE_CMD_WRITE_PARAM |=> param_wr_o && param_wdata_o == $past(op_low)
    && param_index_o == $past(arg_high_i))
    else $error("parameter write wrong");
  c_add: cover property (@(posedge ref_clk_i) disable iff (reset_i) accept && cmd_code_i == SRCE_CMD_ADD);
  c_weld: cover property (@(posedge ref_clk_i) disable iff (reset_i) weld_start_o);
  c_read: cover property (@(posedge ref_clk_i) disable iff (reset_i) param_rd_o ##[1:8] param_rvalid_i);
endmodule : srce_executor
`default_nettype wire

/* verilog/srce_pkg.sv */
// Package with the command codes, sizes and reset values of the sequence command executor.
package srce_pkg;
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] SRCE_CMD_ADD = 8'h3d;
  localparam logic [7:0] SRCE_CMD_SAVE_PULSE = 8'h3e;
  localparam logic [7:0] SRCE_CMD_LOAD_FIRST = 8'h3f;
  localparam logic [7:0] SRCE_CMD_LOAD_LAST = 8'h48;
  localparam logic [7:0] SRCE_CMD_INC_LOOP = 8'h49;
  localparam logic [7:0] SRCE_CMD_START_WELD = 8'h4a;
  localparam logic [7:0] SRCE_CMD_READ_PARAM = 8'h4b;
  localparam logic [7:0] SRCE_CMD_WRITE_PARAM = 8'h4c;
  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int SRCE_REG_COUNT = 11;
  localparam int SRCE_LOOP_COUNT = 10;
  localparam logic [15:0] SRCE_REG_RESET = 16'h0000;
  localparam logic [15:0] SRCE_LOOP_RESET = 16'h0000;
  localparam logic [1:0] SRCE_CC_RESET = 2'h0;
  // Condition code bits: zero and carry.
  localparam int SRCE_CC_ZERO = 0;
  localparam int SRCE_CC_CARRY = 1;
  typedef enum logic [1:0] {SRCE_IDLE, SRCE_PARAM_WAIT} srce_state_type;
endpackage : srce_pkg

/* verilog/srce_adder.sv */
// Adder that forms the register sum and its condition code.
`timescale 1ns/1ns
`default_nettype none
module srce_adder (
  // Operands
  input wire logic [15:0] a_i,
  input wire logic [15:0] b_i,
  // Result
  output logic [15:0] sum_o,
  output logic [1:0] cc_o
);
  import srce_pkg::*;
  logic [16:0] full;
  assign full = {1'b0, a_i} + {1'b0, b_i};
  assign sum_o = full[15:0];
  assign cc_o[SRCE_CC_ZERO] = (full[15:0] == 16'h0000);
  assign cc_o[SRCE_CC_CARRY] = full[16];
endmodule : srce_adder
`default_nettype wire

/* verif/srce_param_store.sv */
// Behavioural weld schedule parameter store that answers reads after a chosen latency.
`timescale 1ns/1ns
`default_nettype none
module srce_param_store (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Parameter port
  input wire logic param_rd_i,
  input wire logic param_wr_i,
  input wire logic [7:0] param_index_i,
  input wire logic [15:0] param_wdata_i,
  input wire logic [3:0] latency_i,
  output logic [15:0] param_rdata_o,
  output logic param_rvalid_o
);
  logic [15:0] mem [256];
  logic [7:0] ridx;
  logic [3:0] cnt;
  logic pend;
  initial foreach (mem[i]) mem[i] = {8'(i), ~8'(i)};
  // Read data toggles outside the valid cycle so a stale value never passes.
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      param_rvalid_o <= 1'b0;
      param_rdata_o <= 16'h0000;
      pend <= 1'b0;
      cnt <= 4'h0;
      ridx <= 8'h00;
    end else begin
      param_rvalid_o <= 1'b0;
      param_rdata_o <= ~param_rdata_o;
      if (param_wr_i) mem[param_index_i] <= param_wdata_i;
      if (param_rd_i) begin
        pend <= 1'b1;
        cnt <= latency_i;
        ridx <= param_index_i;
      end else if (pend && cnt == 4'h0) begin
        pend <= 1'b0;
        param_rvalid_o <= 1'b1;
        param_rdata_o <= mem[ridx];
      end else if (pend) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : srce_param_store
`default_nettype wire

/* verif/sequence_register_command_executor_test.sv */
// Self-checking testbench for the sequence command executor.
`timescale 1ns/1ns
`default_nettype none
module sequence_register_command_executor_test;
  import srce_pkg::*;
  logic ref_clk_i = 1'b0, reset_i = 1'b1, cmd_valid_i = 1'b0;
  logic [7:0] cmd_code_i = 8'h00, arg_high_i = 8'h00, arg_low_i = 8'h00;
  logic [15:0] pulse_accum_i = 16'h0000;
  logic [3:0] lat = 4'h0;
  wire logic cmd_done_o, weld_start_o, param_rd_o, param_wr_o, param_rvalid_i;
  wire logic [15:0] weld_schedule_o, param_wdata_o, param_rdata_i;
  wire logic [7:0] param_index_o;
  wire logic [1:0] cond_code_o;
  int num_errors = 0, tests_run = 0, cycles = 0;
  logic s_start, s_wr, s_rd;
  logic [15:0] s_wdata;
  logic [7:0] s_idx;
  srce_executor dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .arg_high_i(arg_high_i), .arg_low_i(arg_low_i), .cmd_done_o(cmd_done_o),
    .pulse_accum_i(pulse_accum_i), .weld_start_o(weld_start_o), .weld_schedule_o(weld_schedule_o),
    .param_rd_o(param_rd_o), .param_wr_o(param_wr_o), .param_index_o(param_index_o),
    .param_wdata_o(param_wdata_o), .param_rdata_i(param_rdata_i), .param_rvalid_i(param_rvalid_i),
    .cond_code_o(cond_code_o));
  srce_param_store store (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .param_rd_i(param_rd_o),
    .param_wr_i(param_wr_o), .param_index_i(param_index_o), .param_wdata_i(param_wdata_o),
    .latency_i(lat), .param_rdata_o(param_rdata_i), .param_rvalid_o(param_rvalid_i));
  initial forever #50 ref_clk_i = ~ref_clk_i;
  task print_verdict();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // The ceiling is far above the roughly 120 cycles the tests need.
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end
  task check(string name, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp=%h seen=%h", name, exp, seen);
    end
  endtask : check
  // Issues one command for one cycle, samples the read pulse in the next cycle and the other pulses in the done cycle.
  task issue(logic [7:0] code, logic [7:0] hi, logic [7:0] lo);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    cmd_code_i = code;
    arg_high_i = hi;
    arg_low_i = lo;
    cmd_valid_i = 1'b1;
    @(negedge ref_clk_i);
    cmd_valid_i = 1'b0;
    s_rd = param_rd_o;
    while (cmd_done_o !== 1'b1 && n < 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    check("done", {15'h0, cmd_done_o}, 16'h1);
    s_start = weld_start_o;
    s_wr = param_wr_o;
    s_wdata = param_wdata_o;
    s_idx = param_index_o;
  endtask : issue
  // Reads a register back by writing it to a scratch parameter.
  task peek(logic [7:0] r, logic [15:0] exp);
    issue(SRCE_CMD_WRITE_PARAM, 8'hf0, r);
    check("wr", {15'h0, s_wr}, 16'h1);
    check("idx", {8'h0, s_idx}, 16'h00f0);
    check("wdata", s_wdata, exp);
  endtask : peek
  task t_load();
    for (int k = 0; k < 10; k++) issue(8'(SRCE_CMD_LOAD_FIRST + k), 8'(k + 1), 8'(8'ha0 + k));
    for (int k = 0; k < 10; k++) peek(8'(k + 1), {8'(k + 1), 8'(8'ha0 + k)});
  endtask : t_load
  task t_add();
    issue(SRCE_CMD_LOAD_FIRST, 8'h12, 8'h34);
    issue(8'h40, 8'h0f, 8'h0f);
    issue(SRCE_CMD_ADD, 8'h01, 8'h02);
    check("cc", {14'h0, cond_code_o}, 16'h0000);
    peek(8'h00, 16'h2143);
    issue(SRCE_CMD_LOAD_FIRST, 8'hff, 8'hff);
    issue(8'h40, 8'h00, 8'h01);
    issue(SRCE_CMD_ADD, 8'h02, 8'h01);
    check("cc", {14'h0, cond_code_o}, 16'h0003);
    peek(8'h00, 16'h0000);
  endtask : t_add
  task t_pulse();
    pulse_accum_i = 16'hbeef;
    issue(SRCE_CMD_SAVE_PULSE, 8'h00, 8'h04);
    pulse_accum_i = 16'h1357;
    peek(8'h04, 16'hbeef);
  endtask : t_pulse
  task t_loop();
    issue(SRCE_CMD_INC_LOOP, 8'h00, 8'h02);
    issue(SRCE_CMD_INC_LOOP, 8'h00, 8'h02);
    issue(SRCE_CMD_INC_LOOP, 8'h00, 8'h09);
    issue(SRCE_CMD_START_WELD, 8'h00, 8'h02);
    check("start", {15'h0, s_start}, 16'h1);
    check("sched", weld_schedule_o, 16'h0002);
    issue(SRCE_CMD_START_WELD, 8'h00, 8'h09);
    check("sched9", weld_schedule_o, 16'h0001);
    issue(SRCE_CMD_START_WELD, 8'h00, 8'h0a);
    check("nostart", {15'h0, s_start}, 16'h0);
  endtask : t_loop
  task t_param();
    lat = 4'h0;
    issue(SRCE_CMD_READ_PARAM, 8'h0a, 8'h05);
    check("rd", {15'h0, s_rd}, 16'h1);
    check("ridx", {8'h0, s_idx}, 16'h000a);
    peek(8'h05, 16'h0af5);
    issue(SRCE_CMD_READ_PARAM, 8'h0b, 8'h15);
    peek(8'h05, 16'h0af5);
    lat = 4'h6;
    issue(SRCE_CMD_LOAD_FIRST, 8'hc3, 8'h3c);
    issue(SRCE_CMD_WRITE_PARAM, 8'h30, 8'h01);
    issue(SRCE_CMD_READ_PARAM, 8'h30, 8'h06);
    peek(8'h06, 16'hc33c);
  endtask : t_param
  initial begin
    repeat (16) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    reset_i = 1'b0;
    t_load();
    t_add();
    t_pulse();
    t_loop();
    t_param();
    print_verdict();
  end
endmodule : sequence_register_command_executor_test
`default_nettype wire
